/* core/flag_irq_timer_pins.sv */
// Purpose: flag pins, external interrupt inputs and timer expiry pin
// Assumes: interrupt pins asynchronous, active low; core strobes sync
// Notes: expiry pin is a strap input while reset is held
//
// What this block does
// RQ1: Each flag pin direction set by software
// RQ2: Flags are inputs after reset
// RQ3: Sampled flag levels go to sequencer
// RQ4: Enabled interrupt pin raises core request
// RQ5: Per-pin edge or level detection select
// RQ6: Interrupts ignored unless strap and vectors ready
// RQ7: Pulse expiry output when timer zero expires
// RQ8: Expiry pin sampled as strap during reset
// RQ9: Interrupt pins synchronised through two stages
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module flag_irq_timer_pins
  import flag_irq_pkg::*;
#(
  parameter int unsigned flags = n_flags,
  parameter int unsigned irqs = n_irqs
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [flags-1:0] program_flag_pins_in,
  output logic [flags-1:0] program_flag_pins_out,
  output logic [flags-1:0] program_flag_pins_oe,
  output logic [flags-1:0] flag_condition,
  input wire logic [irqs-1:0] external_interrupt_request_pins,
  output logic [irqs-1:0] irq_request,
  input wire logic [irqs-1:0] irq_ack,
  input wire logic timer_zero_expiry,
  input wire logic timer_zero_expired_in,
  output logic timer_zero_expired_out,
  output logic timer_zero_expired_oe,
  output logic boot_strap
);
  logic [flags-1:0] flag_dir_ff;
  logic [flags-1:0] flag_out_ff;
  logic [flags-1:0] flag_in_ff;
  logic [irqs-1:0] irq_enable_ff;
  logic [irqs-1:0] irq_edge_ff;
  logic arm_ff;
  logic strap_ff;
  logic rst_seen_ff;
  logic [irqs-1:0] prev_level_ff;
  logic [irqs-1:0] pending_ff;
  logic [irqs-1:0] nxt_pending;
  logic [irqs-1:0] level;
  logic [irqs-1:0] active;
  logic expired_ff;
  logic [31:0] rdata_ff;
  logic wr_flag_dir;
  logic wr_flag_out;
  logic wr_irq_enable;
  logic wr_irq_edge;
  logic wr_irq_arm;

  irq_sync_if #(.width(irqs)) sync_bus ();

  assign sync_bus.raw_n = external_interrupt_request_pins;

  irq_synchronizer #(.width(irqs)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .port(sync_bus)
  );

  assign level = sync_bus.level;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  // One strobe decode per register keeps the update blocks apart
  assign wr_flag_dir = reg_wr & hit(reg_addr, reg_flag_dir);
  assign wr_flag_out = reg_wr & hit(reg_addr, reg_flag_out);
  assign wr_irq_enable = reg_wr & hit(reg_addr, reg_irq_enable);
  assign wr_irq_edge = reg_wr & hit(reg_addr, reg_irq_edge);
  assign wr_irq_arm = reg_wr & hit(reg_addr, reg_irq_arm);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_dir_ff <= rst_flag_dir[flags-1:0]; // [RQ2]
    end else if (wr_flag_dir) begin
      flag_dir_ff <= reg_wdata[flags-1:0]; // [RQ1]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_out_ff <= rst_flag_out[flags-1:0];
    end else if (wr_flag_out) begin
      flag_out_ff <= reg_wdata[flags-1:0];
    end
  end

  assign program_flag_pins_oe = flag_dir_ff; // [RQ1] [RQ2]
  assign program_flag_pins_out = flag_out_ff;

  // Pins are asynchronous but single-bit conditions; one register stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_in_ff <= '0;
    end else begin
      flag_in_ff <= program_flag_pins_in; // [RQ3]
    end
  end

  assign flag_condition = flag_in_ff; // [RQ3]

  // Clearing an enable bit also drops its pending request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_enable_ff <= rst_irq_enable[irqs-1:0];
    end else if (wr_irq_enable) begin
      irq_enable_ff <= reg_wdata[irqs-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_edge_ff <= rst_irq_edge[irqs-1:0];
    end else if (wr_irq_edge) begin
      irq_edge_ff <= reg_wdata[irqs-1:0]; // [RQ5]
    end
  end

  // Software sets this once its vectors are in place
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arm_ff <= 1'b0;
    end else if (wr_irq_arm) begin
      arm_ff <= reg_wdata[arm_pos]; // [RQ6]
    end
  end

  // Strap caught on the last reset cycle, never under async reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_ff <= timer_zero_expired_in; // [RQ8]
    end
  end

  // Keeps the pin released one cycle past reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_seen_ff <= 1'b1;
    end else begin
      rst_seen_ff <= 1'b0;
    end
  end

  assign boot_strap = strap_ff;

  // Strap and vectors both required before any pin counts
  assign active = irq_enable_ff & {irqs{arm_ff & strap_ff}}; // [RQ6]

  always_comb begin
    nxt_pending = pending_ff & ~irq_ack;
    for (int i = 0; i < irqs; i++) begin
      if (irq_edge_ff[i]) begin
        if (level[i] && !prev_level_ff[i]) begin
          nxt_pending[i] = 1'b1; // [RQ5]
        end
      end else begin
        nxt_pending[i] = level[i]; // [RQ5]
      end
    end
    nxt_pending = nxt_pending & active; // [RQ6]
  end

  // Idle level is low, so no false edge follows reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_level_ff <= '0;
    end else begin
      prev_level_ff <= level; // [RQ5]
    end
  end

  // Edge set wins over acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pending_ff <= '0;
    end else begin
      pending_ff <= nxt_pending; // [RQ4]
    end
  end

  assign irq_request = pending_ff; // [RQ4]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= timer_zero_expiry; // [RQ7]
    end
  end

  assign timer_zero_expired_out = expired_ff;
  // Driver off while reset holds so the strap can be read
  assign timer_zero_expired_oe = ~sys_rst & ~rst_seen_ff; // [RQ8]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      rdata_ff <= '0;
      case (reg_addr)
        reg_flag_dir: rdata_ff[flags-1:0] <= flag_dir_ff;
        reg_flag_out: rdata_ff[flags-1:0] <= flag_out_ff;
        reg_flag_in: rdata_ff[flags-1:0] <= flag_in_ff;
        reg_irq_enable: rdata_ff[irqs-1:0] <= irq_enable_ff;
        reg_irq_edge: rdata_ff[irqs-1:0] <= irq_edge_ff;
        reg_irq_arm: rdata_ff[arm_pos] <= arm_ff;
        reg_strap: rdata_ff[strap_pos] <= strap_ff;
        reg_irq_pending: rdata_ff[irqs-1:0] <= pending_ff;
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule
`default_nettype wire

/* core/irq_synchronizer.sv */
// Purpose: two-stage synchroniser and polarity flip for interrupt pins
// Assumes: pins are active low and asynchronous
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module irq_synchronizer
  import flag_irq_pkg::*;
#(
  parameter int unsigned width = n_irqs
) (
  input wire logic clk,
  input wire logic sys_rst,
  irq_sync_if.sync port
);
  logic [width-1:0] meta_ff;
  logic [width-1:0] stable_ff;

  // Reset to released level (pins pulled high)
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= '1;
      stable_ff <= '1;
    end else begin
      meta_ff <= port.raw_n; // [RQ9]
      stable_ff <= meta_ff; // [RQ9]
    end
  end

  assign port.level = ~stable_ff;
endmodule
`default_nettype wire

/* include/flag_irq_pkg.sv */
// Purpose: shared constants for the flag, interrupt and timer pin block
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes: register map is a plain strobe port, one-cycle read latency
package flag_irq_pkg;
  localparam int unsigned n_flags = 4;
  localparam int unsigned n_irqs = 4;
  localparam logic [3:0] reg_flag_dir = 4'h0;
  localparam logic [3:0] reg_flag_out = 4'h1;
  localparam logic [3:0] reg_flag_in = 4'h2;
  localparam logic [3:0] reg_irq_enable = 4'h3;
  localparam logic [3:0] reg_irq_edge = 4'h4;
  localparam logic [3:0] reg_irq_arm = 4'h5;
  localparam logic [3:0] reg_strap = 4'h6;
  localparam logic [3:0] reg_irq_pending = 4'h7;
  localparam logic [3:0] rst_flag_dir = 4'h0;
  localparam logic [3:0] rst_flag_out = 4'h0;
  localparam logic [3:0] rst_irq_enable = 4'h0;
  localparam logic [3:0] rst_irq_edge = 4'h0;
  localparam int unsigned sync_stages = 2;
  localparam int unsigned strap_pos = 0;
  localparam int unsigned arm_pos = 0;
endpackage

/* include/irq_sync_if.sv */
// Purpose: carries raw and synchronised interrupt levels
// Assumes: single clock domain on the synchronised side
// Notes: raw side is asynchronous
`timescale 1ns/10ps
`default_nettype none
interface irq_sync_if #(parameter int unsigned width = 4);
  logic [width-1:0] raw_n;
  logic [width-1:0] level;
  modport sync (input raw_n, output level);
  modport user (output raw_n, input level);
endinterface
`default_nettype wire

/* tb/board_model.sv */
// Purpose: board side of flag, irq and timer pins
// Assumes: pull-ups on flag and irq lines
// Notes: board drives a flag only where ben is set
`timescale 1ns/10ps
`default_nettype none
module board_model (
  input wire logic [3:0] program_flag_pins_out,
  input wire logic [3:0] program_flag_pins_oe,
  input wire logic [3:0] ben,
  input wire logic [3:0] bval,
  input wire logic [3:0] irq_low,
  input wire logic timer_zero_expired_out,
  input wire logic timer_zero_expired_oe,
  input wire logic strap,
  output logic [3:0] program_flag_pins_in,
  output logic [3:0] external_interrupt_request_pins,
  output logic timer_zero_expired_in
);
  // Undriven bits float up; the device wins a clash
  assign program_flag_pins_in = program_flag_pins_oe & program_flag_pins_out
    | ~program_flag_pins_oe & (~ben | bval);
  assign external_interrupt_request_pins = ~irq_low;
  assign timer_zero_expired_in = timer_zero_expired_oe ?
    timer_zero_expired_out : strap;
endmodule
`default_nettype wire

/* tb/flag_irq_chk.sv */
// Purpose: port checks for flag, irq and timer pins
// Assumes: one clock, sync reset
// Notes: irq modes are internal, the bench covers them
`timescale 1ns/10ps
`default_nettype none
module flag_irq_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] program_flag_pins_in,
  input wire logic [3:0] program_flag_pins_oe,
  input wire logic [3:0] flag_condition,
  input wire logic [3:0] irq_request,
  input wire logic timer_zero_expiry,
  input wire logic timer_zero_expired_in,
  input wire logic timer_zero_expired_out,
  input wire logic timer_zero_expired_oe,
  input wire logic boot_strap
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_exp;
    timer_zero_expiry ##1 timer_zero_expired_out;
  endsequence
  // Pin stays a strap input one cycle past reset
  sequence s_oe;
    !timer_zero_expired_oe ##1 timer_zero_expired_oe;
  endsequence
  AST_RST_OE:
    assert property ($fell(sys_rst) |-> !program_flag_pins_oe)
    else $error("flag oe after reset");
  AST_RST_IRQ: assert property ($fell(sys_rst) |-> !irq_request)
    else $error("irq after reset");
  AST_GATE: assert property (|irq_request |-> boot_strap)
    else $error("irq without strap");
  AST_COND:
    assert property (!$past(sys_rst) |->
      flag_condition == $past(program_flag_pins_in))
    else $error("flag condition");
  AST_EXP: assert property (timer_zero_expiry |-> s_exp)
    else $error("expiry pulse");
  AST_EXP_OE: assert property ($fell(sys_rst) |-> s_oe)
    else $error("expiry pin enable");
  AST_STRAP:
    assert property ($fell(sys_rst) |->
      boot_strap == $past(timer_zero_expired_in))
    else $error("strap capture");
  AST_STRAP_HOLD:
    assert property (!$fell(sys_rst) |-> $stable(boot_strap))
    else $error("strap moved");
endmodule
`default_nettype wire

/* tb/flag_irq_timer_pins_tb.sv */
// Purpose: bench for flag_irq_timer_pins
// Assumes: board_model sits on the pins
// Notes: fixed seed, idle-board corner first
`timescale 1ns/10ps
`default_nettype none
module flag_irq_timer_pins_tb
  import flag_irq_pkg::*;
;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, strap = 1;
  logic timer_zero_expiry = 0, timer_zero_expired_in, timer_zero_expired_out;
  logic timer_zero_expired_oe, boot_strap;
  logic [3:0] reg_addr = 0, ben = 0, bval = 0, irq_low = 0, irq_ack = 0;
  logic [3:0] program_flag_pins_in, program_flag_pins_out, program_flag_pins_oe;
  logic [3:0] flag_condition, irq_request, external_interrupt_request_pins;
  logic [31:0] reg_wdata = 0, reg_rdata, d, r;
  integer seed = 32'hf9ca;
  int num_errors = 0, n_compared = 0;
  initial forever #10 clk = ~clk;
  flag_irq_timer_pins u_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .program_flag_pins_in(program_flag_pins_in),
    .program_flag_pins_out(program_flag_pins_out),
    .program_flag_pins_oe(program_flag_pins_oe),
    .flag_condition(flag_condition),
    .external_interrupt_request_pins(external_interrupt_request_pins),
    .irq_request(irq_request),
    .irq_ack(irq_ack),
    .timer_zero_expiry(timer_zero_expiry),
    .timer_zero_expired_in(timer_zero_expired_in),
    .timer_zero_expired_out(timer_zero_expired_out),
    .timer_zero_expired_oe(timer_zero_expired_oe),
    .boot_strap(boot_strap)
  );
  board_model u_brd (
    .program_flag_pins_out(program_flag_pins_out),
    .program_flag_pins_oe(program_flag_pins_oe),
    .ben(ben),
    .bval(bval),
    .irq_low(irq_low),
    .timer_zero_expired_out(timer_zero_expired_out),
    .timer_zero_expired_oe(timer_zero_expired_oe),
    .strap(strap),
    .program_flag_pins_in(program_flag_pins_in),
    .external_interrupt_request_pins(external_interrupt_request_pins),
    .timer_zero_expired_in(timer_zero_expired_in)
  );
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Idle cycle after each strobe avoids double assignment
  task automatic acc(input logic w, input logic [3:0] a, input logic [3:0] v);
    reg_addr <= a;
    reg_wdata <= {28'h0, v};
    reg_wr <= w;
    reg_rd <= !w;
    cyc(1);
    {reg_wr, reg_rd} <= 2'h0;
    d = reg_rdata;
    cyc(1);
  endtask
  task automatic cmp(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  function automatic logic [31:0] pin_f(input logic [15:0] x);
    return {28'h0, x[3:0] & x[7:4] | ~x[3:0] & (~x[11:8] | x[15:12])};
  endfunction
  task automatic conclude;
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    conclude();
  end
  initial begin
    cyc(12);
    sys_rst <= 1'h0;
    strap <= 1'h0;
    cyc(1);
    cmp("strap", 1, boot_strap);
    cmp("oe", 0, program_flag_pins_oe);
    for (int i = 0; i < 9; i++) begin
      r = i ? $random(seed) : 32'h0;
      acc(1, reg_flag_dir, r[3:0]);
      acc(1, reg_flag_out, r[7:4]);
      acc(0, reg_flag_dir, 4'h0);
      cmp("dir reg", {28'h0, r[3:0]}, d);
      acc(0, reg_flag_out, 4'h0);
      cmp("out reg", {28'h0, r[7:4]}, d);
      ben <= r[11:8];
      bval <= r[15:12];
      cyc(2);
      acc(0, reg_flag_in, 4'h0);
      cmp("oe", {28'h0, r[3:0]}, program_flag_pins_oe);
      cmp("flag_in", pin_f(r[15:0]), d);
      cmp("cond", pin_f(r[15:0]), flag_condition);
    end
    acc(0, reg_strap, 4'h0);
    cmp("strap reg", 1, d);
    acc(0, 4'hf, 4'h0);
    cmp("unmapped", 0, d);
    acc(1, reg_irq_enable, 4'hf);
    acc(1, reg_irq_edge, 4'h1);
    acc(0, reg_irq_enable, 4'h0);
    cmp("enable reg", 32'hf, d);
    acc(0, reg_irq_edge, 4'h0);
    cmp("edge reg", 1, d);
    irq_low <= 4'h3;
    cyc(5);
    cmp("unarmed", 0, irq_request);
    irq_low <= 4'h0;
    acc(1, reg_irq_arm, 4'h1);
    acc(0, reg_irq_arm, 4'h0);
    cmp("arm reg", 1, d);
    cyc(4);
    irq_low <= 4'h3;
    cyc(2);
    cmp("sync", 0, irq_request);
    cyc(1);
    cmp("raised", 3, irq_request);
    irq_low <= 4'h0;
    cyc(4);
    cmp("edge held", 1, irq_request);
    acc(0, reg_irq_pending, 4'h0);
    cmp("pending reg", 1, d);
    irq_ack <= 4'h1;
    cyc(1);
    irq_ack <= 4'h0;
    cyc(2);
    cmp("acked", 0, irq_request);
    timer_zero_expiry <= 1'h1;
    cyc(1);
    timer_zero_expiry <= 1'h0;
    cmp("expired", 1, timer_zero_expired_in);
    cyc(1);
    cmp("expired end", 0, timer_zero_expired_out);
    // Second reset with the strap low: interrupts must stay blocked
    sys_rst <= 1'h1;
    cyc(3);
    sys_rst <= 1'h0;
    cyc(1);
    cmp("strap low", 0, boot_strap);
    cmp("oe rst", 0, program_flag_pins_oe);
    acc(1, reg_irq_enable, 4'hf);
    acc(1, reg_irq_arm, 4'h1);
    irq_low <= 4'hf;
    cyc(5);
    cmp("no strap", 0, irq_request);
    acc(0, reg_strap, 4'h0);
    cmp("strap reg low", 0, d);
    conclude();
  end
endmodule
bind flag_irq_timer_pins flag_irq_chk u_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .program_flag_pins_in(program_flag_pins_in),
  .program_flag_pins_oe(program_flag_pins_oe),
  .flag_condition(flag_condition),
  .irq_request(irq_request),
  .timer_zero_expiry(timer_zero_expiry),
  .timer_zero_expired_in(timer_zero_expired_in),
  .timer_zero_expired_out(timer_zero_expired_out),
  .timer_zero_expired_oe(timer_zero_expired_oe),
  .boot_strap(boot_strap)
);
`default_nettype wire
